// file: logic/mss_seq.sv
// start-up decision and position initialisation sequencer with an APB register file
// assumes the speed detector and the current comparator live on pclk; the ramp stage takes over at done
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - speed detect enabled: sense speed, position, direction
// - speed detect disabled: go straight to brake check
// - forward spin with resync: load state, keep running
// - forward spin, resync off: go to coast check
// - reverse spin with reverse drive: decelerate, cross zero
// - reverse select chooses dedicated or forward parameters
// - reverse closed loop hands off at threshold
// - reversal uses reverse current limit and coefficients
// - reverse decel is percent of reverse accel
// - method field picks align, double, detection or slow first cycle
// - align injects dc at angle for time
// - align current ramps up from zero gradually
// - double align adds second pattern 90 ahead
// - six detection patterns in fixed order
// - stop pulse at threshold, record rise time
// - shortest rise time gives rotor position
// - release mode: recirculate low c or all off
// - open loop starts at detected angle plus advance
// - method 11b starts with slow first cycle
// - resync above threshold closed loop, else open
// - coast turns all switches off for coast time
module mss_seq
  import mss_pkg::*;
#(
  parameter int TW = 16
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          isd_valid,
  input  wire logic          isd_moving,
  input  wire logic          isd_reverse,
  input  wire logic [15:0]   isd_speed,
  input  wire logic [15:0]   isd_angle,
  input  wire logic          current_over,
  output mss_gate_t          gate_r,
  output logic [15:0]        drive_angle_r,
  output logic [15:0]        current_ref_r,
  output logic [15:0]        ol_current_limit_r,
  output logic [15:0]        ol_accel_one_r,
  output logic [15:0]        ol_accel_two_r,
  output logic [15:0]        ol_decel_rate_r,
  output logic [15:0]        handoff_speed_r,
  output logic               slow_first_cycle_r,
  output logic               isd_start_r,
  output logic               done_r,
  output mss_result_t        result_r
);

  if (TW < 8 || TW > 24) begin : g_tw_check
    $error("mss_seq: TW out of range");
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [31:0] regs_r [MSS_REG_WORDS];                // one word per aligned address; status and result slots stay zero
  wire  [31:0] ctrl_r  = regs_r[MSS_ADDR_CTRL[5:2]];  // control bits and method field
  wire  [31:0] align_r = regs_r[MSS_ADDR_ALIGN[5:2]]; // [15:0] align angle, [31:16] align time in us
  wire  [31:0] ipd_r   = regs_r[MSS_ADDR_IPD[5:2]];   // [15:0] advance angle, [31:16] rest time in us
  wire  [31:0] rev_r   = regs_r[MSS_ADDR_REV[5:2]];   // [15:0] reverse current, [23:16] decel percent
  wire  [31:0] thr_r   = regs_r[MSS_ADDR_THR[5:2]];   // [15:0] resync threshold, [31:16] reverse handoff
  wire  [31:0] ramp_r  = regs_r[MSS_ADDR_RAMP[5:2]];  // [15:0] align current limit, [31:16] ramp step
  wire  [31:0] coast_r = regs_r[MSS_ADDR_COAST[5:2]]; // [15:0] coast time in us
  wire  [31:0] fwd_r   = regs_r[MSS_ADDR_FWD[5:2]];   // [15:0] forward current limit, [31:16] forward handoff
  wire  [31:0] acc_r   = regs_r[MSS_ADDR_ACC[5:2]];   // [15:0] forward accel one, [31:16] forward accel two
  wire  [31:0] racc_r  = regs_r[MSS_ADDR_RACC[5:2]];  // [15:0] reverse accel one, [31:16] reverse accel two
  wire  [31:0] slow_r  = regs_r[MSS_ADDR_SLOW[5:2]];  // [15:0] first cycle frequency
  mss_state_t  state_r;

  wire addr_ok = (paddr <= MSS_ADDR_SLOW) && (paddr[1:0] == 2'h0);
  wire wr_ok   = addr_ok && (paddr != MSS_ADDR_STATUS) && (paddr != MSS_ADDR_RESULT);
  wire wr_en   = psel & penable & pwrite & wr_ok;

  // writes land in the access cycle; pready is always high so no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < MSS_REG_WORDS; i++) regs_r[i] <= 32'h0000_0000;
    end else begin
      if (state_r != MSS_IDLE) regs_r[MSS_ADDR_CTRL[5:2]][MSS_B_START] <= 1'b0;  // start self-clears once taken
      if (wr_en) regs_r[paddr[5:2]] <= pwdata;  // a write in the same cycle wins over the self-clear
    end
  end

  // read mux registered in the setup cycle so data is ready at the access edge
  logic [31:0] rd_nxt;
  logic [2:0]  pick_r;
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (paddr)
      MSS_ADDR_STATUS: rd_nxt = {13'h0000, pick_r, 5'h00, state_r};
      MSS_ADDR_RESULT: rd_nxt = {13'h0000, result_r};
      default:         rd_nxt = addr_ok ? regs_r[paddr[5:2]] : 32'h0000_0000;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b1;
      pslverr <= 1'b0;
    end else begin
      pready  <= 1'b1;
      if (psel && !penable) begin
        prdata  <= rd_nxt;
        pslverr <= !addr_ok;  // unmapped words answer with an error, data zero
      end
    end
  end

  // ----------------------------------------------------------------
  // microsecond tick and phase timer
  // ----------------------------------------------------------------
  localparam logic [7:0] TICK_LAST = 8'(MSS_CYC_PER_TICK - 1);
  logic [7:0]    pre_r;
  logic [TW-1:0] tmr_r;
  logic          tmr_clr;
  wire           tick = (pre_r == TICK_LAST);

  // phase time counts in microseconds; cleared on each state change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= 8'h00;
      tmr_r <= '0;
    end else if (tmr_clr) begin
      pre_r <= 8'h00;
      tmr_r <= '0;
    end else begin
      pre_r <= tick ? 8'h00 : pre_r + 8'h01;
      if (tick && tmr_r != '1) tmr_r <= tmr_r + 1'b1;
    end
  end

  // pulse rise time in clock cycles, saturating, so short rises still resolve
  logic [TW-1:0] rise_r;
  logic [TW-1:0] best_r;
  logic [2:0]    pat_r;
  logic          align2_r;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  mss_state_t st_nxt;
  wire [1:0]  mode    = ctrl_r[MSS_B_MODE+1:MSS_B_MODE];
  wire        timeout = (tmr_r >= align_r[31:16]);
  wire        fwd_ok  = isd_moving && (isd_reverse == ctrl_r[MSS_B_DIR]);
  always_comb begin
    st_nxt = state_r;
    case (state_r)
      MSS_IDLE:   if (ctrl_r[MSS_B_START]) st_nxt = ctrl_r[MSS_B_ISD] ? MSS_ISD : MSS_BRKCHK;
      MSS_ISD:    if (isd_valid) st_nxt = MSS_JUDGE;
      MSS_JUDGE: begin
        if (!isd_moving) st_nxt = MSS_BRKCHK;
        else if (fwd_ok && ctrl_r[MSS_B_RESYNC]) st_nxt = MSS_DONE;
        else if (!fwd_ok && ctrl_r[MSS_B_REVEN]) st_nxt = MSS_DONE;
        else st_nxt = ctrl_r[MSS_B_COAST] ? MSS_COAST : MSS_BRKCHK;
      end
      MSS_COAST:  if (tmr_r >= coast_r[15:0]) st_nxt = MSS_BRKCHK;
      MSS_BRKCHK: begin
        // braking is handled outside; here the method field decides the start
        case (mode)
          MSS_MODE_ALIGN, MSS_MODE_DOUBLE: st_nxt = MSS_ALIGN1;
          MSS_MODE_IPD:                    st_nxt = MSS_PULSE;
          default:                         st_nxt = MSS_DONE;
        endcase
      end
      MSS_ALIGN1: if (timeout) st_nxt = (mode == MSS_MODE_DOUBLE) ? MSS_ALIGN2 : MSS_DONE;
      MSS_ALIGN2: if (timeout) st_nxt = MSS_DONE;
      MSS_PULSE:  if (current_over) st_nxt = MSS_REST;
      MSS_REST:   if (tmr_r >= ipd_r[31:16]) st_nxt = (pat_r == 3'(MSS_IPD_COUNT - 1)) ? MSS_PICK : MSS_PULSE;
      MSS_PICK:   st_nxt = MSS_DONE;
      MSS_DONE:   st_nxt = MSS_IDLE;
      default:    st_nxt = MSS_IDLE;
    endcase
  end
  assign tmr_clr = (st_nxt != state_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state_r <= MSS_IDLE;
    else          state_r <= st_nxt;
  end

  // detection pattern walk, rise timing and minimum search
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pat_r  <= 3'h0;
      rise_r <= '0;
      best_r <= '1;
      pick_r <= 3'h0;
    end else begin
      if (state_r == MSS_BRKCHK) begin
        pat_r  <= 3'h0;
        best_r <= '1;
        pick_r <= 3'h0;
      end
      if (state_r == MSS_PULSE) begin
        if (current_over) begin
          if (rise_r < best_r) begin
            best_r <= rise_r;
            pick_r <= pat_r;
          end
          rise_r <= '0;
        end else if (rise_r != '1) begin
          rise_r <= rise_r + 1'b1;
        end
      end
      if (state_r == MSS_REST && st_nxt == MSS_PULSE) pat_r <= pat_r + 3'h1;
    end
  end

  // pattern angle: BC, CB, AB, BA, CA, AC each a sixth of a turn apart
  function automatic logic [15:0] pat_angle(input logic [2:0] p);
    case (p)
      3'h0:    pat_angle = 16'h4000;
      3'h1:    pat_angle = 16'hc000;
      3'h2:    pat_angle = 16'h9555;
      3'h3:    pat_angle = 16'h1555;
      3'h4:    pat_angle = 16'heaab;
      default: pat_angle = 16'h6aab;
    endcase
  endfunction

  // gate word for a detection pattern: first letter high side, second low side
  function automatic mss_gate_t pat_gate(input logic [2:0] p);
    case (p)
      3'h0:    pat_gate = 6'b00_10_01;
      3'h1:    pat_gate = 6'b00_01_10;
      3'h2:    pat_gate = 6'b10_01_00;
      3'h3:    pat_gate = 6'b01_10_00;
      3'h4:    pat_gate = 6'b01_00_10;
      default: pat_gate = 6'b10_00_01;
    endcase
  endfunction

  // gates: coast all off, pulse drives pattern, release keeps only low side c or nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gate_r <= 6'b00_00_00;
    else case (st_nxt)
      MSS_PULSE: gate_r <= pat_gate((state_r == MSS_REST) ? pat_r + 3'h1 : (state_r == MSS_BRKCHK) ? 3'h0 : pat_r);
      MSS_REST:  gate_r <= ctrl_r[MSS_B_RLS] ? 6'b00_00_00 : 6'b00_00_01;
      default:   gate_r <= 6'b00_00_00;
    endcase
  end

  // align angle and current ramp; the pwm stage applies current_ref at drive_angle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_angle_r <= 16'h0000;
      current_ref_r <= 16'h0000;
      align2_r      <= 1'b0;
    end else begin
      align2_r <= (state_r == MSS_ALIGN2);
      if (state_r == MSS_ALIGN1) drive_angle_r <= align_r[15:0];
      else if (state_r == MSS_ALIGN2) drive_angle_r <= align_r[15:0] + MSS_ANGLE_90;
      if (state_r == MSS_ALIGN1 || state_r == MSS_ALIGN2) begin
        if (state_r == MSS_ALIGN2 && !align2_r) current_ref_r <= 16'h0000;
        else if (tick) current_ref_r <= (ramp_r[15:0] - current_ref_r > ramp_r[31:16]) ?
                                        current_ref_r + ramp_r[31:16] : ramp_r[15:0];
      end else begin
        current_ref_r <= 16'h0000;
      end
    end
  end

  // open-loop parameter set chosen for the hand-off
  wire rev_path = (state_r == MSS_JUDGE) && !fwd_ok;
  wire use_rev  = rev_path && ctrl_r[MSS_B_REVSEL];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ol_current_limit_r <= 16'h0000;
      ol_accel_one_r     <= 16'h0000;
      ol_accel_two_r     <= 16'h0000;
      ol_decel_rate_r    <= 16'h0000;
      handoff_speed_r    <= 16'h0000;
      slow_first_cycle_r <= 1'b0;
    end else if (st_nxt == MSS_DONE && state_r != MSS_DONE) begin
      ol_current_limit_r <= use_rev ? rev_r[15:0]  : fwd_r[15:0];
      ol_accel_one_r     <= use_rev ? racc_r[15:0] : acc_r[15:0];
      ol_accel_two_r     <= use_rev ? racc_r[31:16] : acc_r[31:16];
      ol_decel_rate_r    <= 16'((32'(use_rev ? racc_r[15:0] : acc_r[15:0]) *
                            32'(use_rev ? rev_r[23:16] : 8'h64)) / 32'd100);
      handoff_speed_r    <= use_rev ? thr_r[31:16] : fwd_r[31:16];
      slow_first_cycle_r <= (state_r == MSS_BRKCHK) && (mode == MSS_MODE_SLOW);
    end
  end

  // completion result and pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r      <= 1'b0;
      isd_start_r <= 1'b0;
      result_r    <= '0;
    end else begin
      isd_start_r <= (st_nxt == MSS_ISD);
      done_r      <= (state_r == MSS_DONE);
      if (st_nxt == MSS_DONE && state_r != MSS_DONE) begin
        result_r.reverse <= rev_path;
        if (state_r == MSS_JUDGE) begin
          result_r.angle <= isd_angle;
          if (rev_path) result_r.go <= (isd_speed > handoff_sel()) ? MSS_GO_REV_CL : MSS_GO_REV_OL;
          else result_r.go <= (isd_speed > thr_r[15:0]) ? MSS_GO_CLOSED : MSS_GO_OPEN;
        end else if (state_r == MSS_PICK) begin
          result_r.angle <= pat_angle(pick_r) + ipd_r[15:0];
          result_r.go    <= MSS_GO_OPEN;
        end else begin
          result_r.angle <= drive_angle_r;
          result_r.go    <= MSS_GO_OPEN;
        end
      end
    end
  end

  function automatic logic [15:0] handoff_sel();
    handoff_sel = ctrl_r[MSS_B_REVSEL] ? thr_r[31:16] : fwd_r[31:16];
  endfunction

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence pulse_end_s;
    state_r == MSS_PULSE && current_over;
  endsequence

  release_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    pulse_end_s |=> (gate_r == (ctrl_r[MSS_B_RLS] ? 6'b00_00_00 : 6'b00_00_01)))
    else $error("release gates wrong");
  coast_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == MSS_COAST |-> gate_r == 6'b00_00_00) else $error("gates on during coast");
  skip_isd_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == MSS_IDLE && ctrl_r[MSS_B_START] && !ctrl_r[MSS_B_ISD] |=> state_r == MSS_BRKCHK)
    else $error("speed detect not skipped");
  done_once_a: assert property (@(posedge pclk) disable iff (!presetn)
    done_r |=> !done_r) else $error("done longer than one cycle");
  ramp_limit_a: assert property (@(posedge pclk) disable iff (!presetn)
    current_ref_r <= ramp_r[15:0] || $changed(ramp_r)) else $error("align current above limit");
  second_align_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == MSS_ALIGN2 ##1 state_r == MSS_ALIGN2 |-> drive_angle_r == align_r[15:0] + MSS_ANGLE_90)
    else $error("second align angle wrong");
  pattern_count_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == MSS_PICK |-> pat_r == 3'h5) else $error("detection pattern count wrong");
  resync_go_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == MSS_JUDGE && fwd_ok && ctrl_r[MSS_B_RESYNC] && isd_speed > thr_r[15:0]
    |=> result_r.go == MSS_GO_CLOSED ##1 done_r) else $error("resync path wrong");

endmodule : mss_seq

`default_nettype wire

// file: logic/mss_pkg.sv
// package for the motor start-up sequencer: angles, states, phase patterns, timing
// assumes a 16-bit electrical angle where 0x10000 is one full turn
package mss_pkg;

  // ----------------------------------------------------------------
  // angle and pattern constants
  // ----------------------------------------------------------------
  localparam logic [15:0] MSS_ANGLE_90    = 16'h4000;
  localparam int          MSS_IPD_COUNT   = 6;
  localparam logic [1:0]  MSS_MODE_ALIGN  = 2'h0;
  localparam logic [1:0]  MSS_MODE_DOUBLE = 2'h1;
  localparam logic [1:0]  MSS_MODE_IPD    = 2'h2;
  localparam logic [1:0]  MSS_MODE_SLOW   = 2'h3;

  // ----------------------------------------------------------------
  // timing: pclk rate and its derived cycles per microsecond
  // ----------------------------------------------------------------
  localparam int MSS_CLK_HZ        = 40000000;
  localparam int MSS_TICK_US       = 1;
  localparam int MSS_CYC_PER_TICK  = (MSS_CLK_HZ / 1000000) * MSS_TICK_US;

  // ----------------------------------------------------------------
  // register map (APB byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] MSS_ADDR_CTRL   = 8'h00;
  localparam logic [7:0] MSS_ADDR_ALIGN  = 8'h04;
  localparam logic [7:0] MSS_ADDR_IPD    = 8'h08;
  localparam logic [7:0] MSS_ADDR_REV    = 8'h0c;
  localparam logic [7:0] MSS_ADDR_THR    = 8'h10;
  localparam logic [7:0] MSS_ADDR_STATUS = 8'h14;
  localparam logic [7:0] MSS_ADDR_RESULT = 8'h18;
  localparam logic [7:0] MSS_ADDR_RAMP   = 8'h1c;
  localparam logic [7:0] MSS_ADDR_COAST  = 8'h20;
  localparam logic [7:0] MSS_ADDR_FWD    = 8'h24;
  localparam logic [7:0] MSS_ADDR_ACC    = 8'h28;
  localparam logic [7:0] MSS_ADDR_RACC   = 8'h2c;
  localparam logic [7:0] MSS_ADDR_SLOW   = 8'h30;
  localparam int         MSS_REG_WORDS   = 13;

  // control bit positions
  localparam int MSS_B_START  = 0;
  localparam int MSS_B_ISD    = 1;
  localparam int MSS_B_RESYNC = 2;
  localparam int MSS_B_REVEN  = 3;
  localparam int MSS_B_REVSEL = 4;
  localparam int MSS_B_COAST  = 5;
  localparam int MSS_B_BRAKE  = 6;
  localparam int MSS_B_RLS    = 7;
  localparam int MSS_B_MODE   = 8;
  localparam int MSS_B_DIR    = 10;

  // drive-state choice handed on to the ramp stage
  typedef enum logic [1:0] {
    MSS_GO_OPEN   = 2'h0,
    MSS_GO_CLOSED = 2'h1,
    MSS_GO_REV_CL = 2'h2,
    MSS_GO_REV_OL = 2'h3
  } mss_go_t;

  // one-hot sequencer states
  typedef enum logic [10:0] {
    MSS_IDLE   = 11'h001,
    MSS_ISD    = 11'h002,
    MSS_JUDGE  = 11'h004,
    MSS_COAST  = 11'h008,
    MSS_BRKCHK = 11'h010,
    MSS_ALIGN1 = 11'h020,
    MSS_ALIGN2 = 11'h040,
    MSS_PULSE  = 11'h080,
    MSS_REST   = 11'h100,
    MSS_PICK   = 11'h200,
    MSS_DONE   = 11'h400
  } mss_state_t;

  // six-switch gate word: a high, a low, b high, b low, c high, c low
  typedef struct packed {
    logic ah; logic al; logic bh; logic bl; logic ch; logic cl;
  } mss_gate_t;

  // result handed on at completion
  typedef struct packed {
    logic [15:0] angle;
    logic        reverse;
    mss_go_t     go;
  } mss_result_t;

endpackage : mss_pkg

// file: tb/mss_motor.sv
// motor and half-bridge stand-in: current hits the detect level a set time after a pair is driven
// assumes the gate word shares pclk with this model; the bench loads one rise time per pattern
`timescale 1ns/100ps
`default_nettype none
module mss_motor
  import mss_pkg::*;
(
  input  wire logic        pclk,
  input  wire mss_gate_t   gate,
  input  wire logic [47:0] rise,
  output logic             current_over,
  output logic [17:0]      order_r
);
  logic [7:0] cnt_r;
  logic [2:0] idx;
  // ----------------------------------------------------------------
  // pattern decode: one high and one low switch make a current path
  // ----------------------------------------------------------------
  always_comb begin
    case (gate)
      6'b001001: idx = 3'd0;
      6'b000110: idx = 3'd1;
      6'b100100: idx = 3'd2;
      6'b011000: idx = 3'd3;
      6'b010010: idx = 3'd4;
      6'b100001: idx = 3'd5;
      default:   idx = 3'd7;
    endcase
  end
  // current collapses once the pair is released, so each pulse starts from zero
  always_ff @(posedge pclk) begin
    cnt_r <= (idx == 3'd7) ? 8'h00 : cnt_r + {7'h0, cnt_r != 8'hff};
    if (idx != 3'd7 && cnt_r == 8'h00) order_r <= {order_r[14:0], idx};
  end
  assign current_over = (idx != 3'd7) && (cnt_r >= rise[idx*8 +: 8]);
endmodule : mss_motor
`default_nettype wire

// file: tb/mss_seq_test.sv
// self-checking bench for the start-up sequencer: apb set-up, then standstill, detection, resync, reverse and coast start-up paths
// assumes zero-wait apb answers and the motor model closing the current loop
`timescale 1ns/100ps
`default_nettype none
module mss_seq_test;
  import mss_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, current_over, err;
  logic        isd_valid, isd_moving, isd_reverse, slow_first_cycle_r, isd_start_r, done_r;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] isd_speed, isd_angle, drive_angle_r, current_ref_r, ol_current_limit_r, ol_accel_one_r;
  logic [15:0] ol_accel_two_r, ol_decel_rate_r, handoff_speed_r, al, adv, pk, first, ang0;
  logic [47:0] rise;
  logic [17:0] order_r;
  mss_gate_t   gate_r;
  mss_result_t result_r, res;
  int          errors, comparisons, seed, k, m, r, lc, ist;

  mss_seq #(.TW(16)) u_mss_seq (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .isd_valid, .isd_moving, .isd_reverse, .isd_speed, .isd_angle, .current_over,
    .gate_r, .drive_angle_r, .current_ref_r, .ol_current_limit_r, .ol_accel_one_r, .ol_accel_two_r,
    .ol_decel_rate_r, .handoff_speed_r, .slow_first_cycle_r, .isd_start_r, .done_r, .result_r);
  mss_motor u_mss_motor (.pclk, .gate(gate_r), .rise, .current_over, .order_r);

  always #12.5 pclk = ~pclk;
  // watch align current build-up and low-c recirculation between pulses
  always @(negedge pclk) begin
    if (current_ref_r > pk) pk = current_ref_r;
    if (first == 16'h0) first = current_ref_r;
    if (gate_r == 6'b000001) lc++;
    if (isd_start_r) ist++;
  end
  // ----------------------------------------------------------------
  // bus, compare and run helpers
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; err = pslverr; psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // start bit self-clears; done is a one-cycle pulse, so look at it on the falling edge
  task automatic run(input logic [31:0] ctrl);
    apb(1'b1, MSS_ADDR_CTRL, ctrl | 32'h1);
    for (k = 0; k < 20000 && done_r !== 1'b1; k++) @(negedge pclk);
    chk("done", done_r, 1'b1);
    res = result_r;
    @(negedge pclk) chk("done_pulse", done_r, 1'b0);
  endtask : run
  function automatic logic [1:0] exp_go(input int c);
    if (c >= 2) return (c == 3) ? MSS_GO_REV_OL : MSS_GO_REV_CL;
    return (c == 1) ? MSS_GO_OPEN : MSS_GO_CLOSED;
  endfunction : exp_go
  task automatic give_verdict;
    if (errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  initial begin
    #2250000;
    errors++;
    give_verdict;
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, isd_valid, isd_moving, isd_reverse} = '0;
    paddr = '0; pwdata = '0; isd_speed = '0; isd_angle = '0; rise = '0;
    errors = 0; comparisons = 0; seed = 32'hc744; pk = '0; first = '0; lc = 0; ist = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, MSS_ADDR_CTRL, '0); chk("ctrl_reset", rd, 32'h0);
    apb(1'b0, 8'h34, '0); chk("unmapped", {31'h0, err}, 32'h1);
    al = $random(seed);
    apb(1'b1, MSS_ADDR_ALIGN, {16'd20, al});
    apb(1'b1, 8'h1c, 32'h0010_0100);
    // ----------------------------------------------------------------
    // standstill start-up, every method, speed detection off
    // ----------------------------------------------------------------
    for (m = 0; m < 4; m++) begin
      pk = '0; first = '0;
      run({21'h0, 1'b0, m[1:0], 8'h0});
      if (m < 2) chk("align_angle", res.angle, 16'(al + (m == 1 ? MSS_ANGLE_90 : 16'h0)));
      if (m < 2) chk("ramp", {pk, first < pk}, {16'h0100, 1'b1});
      chk("slow_first", slow_first_cycle_r, m == 3);
      chk("go_open", res.go, MSS_GO_OPEN);
    end
    chk("isd_skipped", ist, 32'h0);
    // six pulses per release mode; rest of 2 us lets winding current die out
    for (m = 0; m < 2; m++) begin
      r = {$random(seed)} % 6;
      for (k = 0; k < 6; k++) rise[k*8 +: 8] <= (k == r) ? 8'd10 : 8'd20 + 8'({$random(seed)} % 40);
      apb(1'b1, MSS_ADDR_IPD, {16'd2, 16'h0});
      lc = 0;
      run({22'h0, 2'h2, m[0], 7'h0});
      ang0 = res.angle;
      chk("order", order_r, 18'o012345);
      chk("release", lc != 0, m == 0);
      apb(1'b0, MSS_ADDR_STATUS, '0); chk("pick", rd[18:16], r);
      adv = $random(seed);
      apb(1'b1, MSS_ADDR_IPD, {16'd2, adv});
      run({22'h0, 2'h2, m[0], 7'h0});
      chk("advance", 16'(res.angle - ang0), adv);
    end
    // spinning rotor: forward resync fast and slow, reverse with both parameter sets
    apb(1'b1, MSS_ADDR_THR, 32'h0200_0400);
    apb(1'b1, MSS_ADDR_REV, 32'h0064_0123);
    apb(1'b1, 8'h24, 32'h0300_0456);
    apb(1'b1, 8'h28, 32'h0006_0005);
    apb(1'b1, 8'h2c, 32'h0002_0001);
    for (m = 0; m < 4; m++) begin
      ang0 = $random(seed);
      isd_speed <= m[0] ? 16'h0100 : 16'h0800; isd_angle <= ang0; isd_reverse <= m[1];
      isd_valid <= 1'b1; isd_moving <= 1'b1;
      ist = 0;
      run({26'h0, 1'b0, m[0], m[1], 3'b110});
      chk("go", res.go, exp_go(m));
      chk("isd_started", ist != 0, 1'b1);
      chk("reverse", res.reverse, m[1]);
      if (m >= 2) chk("rev_accel_two", ol_accel_two_r, m[0] ? 16'h0002 : 16'h0006);
      if (m == 0) chk("resync_angle", res.angle, ang0);
      if (m >= 2) chk("rev_limit", ol_current_limit_r, m[0] ? 16'h0123 : 16'h0456);
      if (m >= 2) chk("rev_handoff", handoff_speed_r, m[0] ? 16'h0200 : 16'h0300);
      if (m >= 2) chk("rev_accel", ol_accel_one_r, m[0] ? 16'h0001 : 16'h0005);
      if (m == 3) chk("rev_decel", ol_decel_rate_r, 16'h0001);
    end
    // forward spin, resync off, coast on: coast then align from standstill
    apb(1'b1, 8'h20, 32'h2);
    isd_speed <= 16'h0800; isd_reverse <= 1'b0;
    run({26'h0, 6'b100010});
    chk("coast_path", {res.angle, res.go}, {al, MSS_GO_OPEN});
    give_verdict;
  end
endmodule : mss_seq_test
`default_nettype wire
